/* File: hs_dac_pkg.sv */
// Notes on behaviour
// - Every party starts in standard/fast mode; high speed only via the master code.
// - A stop condition drops the device out of high-speed mode.
// - Master code is never acknowledged; device switches to high-speed settings.
// - On an address match the device holds data low through the ninth pulse.
// - Control byte: bits 5:4 load mode, bit 2 broadcast, bit 0 power-down.
// - High data byte follows the control byte, msb first, and is acknowledged.
// - Low data byte follows and is acknowledged.
// - Output update fires on the falling edge ending the low byte acknowledge.
// - High/low pairs may repeat without new address; each pair updates.
// - On stop the device keeps output and mode and waits for start plus address.
// - With power-down set, high byte top three bits carry the power-down mode.
package hs_dac_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h13;     // address bits 7:3
  localparam logic ADDR_LOW_BIT = 1'b0;          // address bit 1
  localparam logic [4:0] MCODE_PREFIX = 5'h01;   // master code bits 7:3
  localparam int LOAD_MSB = 5;
  localparam int LOAD_LSB = 4;
  localparam int BRC_POS = 2;
  localparam int PD_POS = 0;
  localparam int PDM_MSB = 7;
  localparam int PDM_LSB = 5;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;   // count of the eighth bit
  localparam logic [3:0] BIT_ACK = 4'h8;         // count of the ninth bit
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] LOAD_RESET = 2'h0;
  localparam logic [2:0] PDM_RESET = 3'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_WAIT_RS, ST_CTRL, ST_HIGH, ST_LOW, ST_IGNORE
  } state_t;
endpackage : hs_dac_pkg

/* File: link_bit_sampler.sv */
`timescale 1ns/1ps
// link-clock side: catches data on each rising bus clock edge
module link_bit_sampler (
  input wire logic scl,
  input wire logic rstn,
  input wire logic sda_in,
  output logic bit_val,
  output logic bit_tog
);
  // sample data while clock is high, flag each bit by a toggle
  always_ff @(posedge scl or negedge rstn) begin
    if (!rstn) begin
      bit_val <= 1'b0;
      bit_tog <= 1'b0;
    end else begin
      bit_val <= sda_in;
      bit_tog <= ~bit_tog;
    end
  end
endmodule : link_bit_sampler

/* File: hs_i2c_dac_write_slave.sv */
`timescale 1ns/1ps
module hs_i2c_dac_write_slave (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic address_select_pin,
  output logic hs_mode,
  output logic [15:0] dac_word,
  output logic update,
  output logic [1:0] load_mode,
  output logic broadcast_sel,
  output logic powerdown_flag,
  output logic [2:0] powerdown_mode
);
  import hs_dac_pkg::*;

  logic bit_val;
  logic bit_tog;
  logic scl_m, scl_s, scl_d;
  logic sda_m, sda_s, sda_d;
  logic tog_m, tog_s, tog_d, tog_d2;
  logic val_m, val_s;
  logic sel_m, sel_s;
  state_t st;
  state_t next_st;
  logic [3:0] bitcnt;
  logic [6:0] shift;
  logic ack_arm;
  logic ack_seen;
  logic upd_arm;
  logic [7:0] high_byte;
  logic [15:0] pend_word;

  // link-domain sampler
  link_bit_sampler u_sampler (
    .scl(scl),
    .rstn(rstn),
    .sda_in(sda_in),
    .bit_val(bit_val),
    .bit_tog(bit_tog)
  );

  // two-stage synchronisers for pins and the link toggle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {scl_m, scl_s, sda_m, sda_s} <= 4'hf;
      {tog_m, tog_s, val_m, val_s, sel_m, sel_s} <= 6'h00;
    end else begin
      {scl_m, scl_s, sda_m, sda_s} <= {scl, scl_m, sda_in, sda_m};
      {tog_m, tog_s, val_m, val_s} <= {bit_tog, tog_m, bit_val, val_m};
      {sel_m, sel_s} <= {address_select_pin, sel_m};
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {scl_d, sda_d} <= 2'h3;
      {tog_d, tog_d2} <= 2'h0;
    end else begin
      {scl_d, sda_d} <= {scl_s, sda_s};
      {tog_d, tog_d2} <= {tog_s, tog_d};
    end
  end

  // bus events; bit event read one cycle late so the bit value has settled
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det = scl_s && scl_d && !sda_d && sda_s;
  wire scl_fall = scl_d && !scl_s;
  wire bit_evt = tog_d ^ tog_d2;
  wire byte_done = bit_evt && (bitcnt == BIT_LAST_DATA);
  wire ack_slot = bit_evt && (bitcnt == BIT_ACK);
  wire [7:0] byte_val = {shift, val_s};

  // byte decoding
  wire is_mcode = (byte_val[7:3] == MCODE_PREFIX);
  wire addr_ok = (byte_val[7:3] == ADDR_FIXED) && (byte_val[2] == sel_s)
    && (byte_val[1] == ADDR_LOW_BIT) && !byte_val[0];
  wire in_frame = (st == ST_FIRST) || (st == ST_CTRL) || (st == ST_HIGH) || (st == ST_LOW);
  wire take_ack = byte_done && in_frame && (st != ST_FIRST || (!is_mcode && addr_ok));

  // next state of the write sequence
  always_comb begin
    next_st = st;
    if (byte_done) begin
      case (st)
        ST_FIRST: begin
          if (is_mcode) begin
            next_st = ST_WAIT_RS;
          end else if (addr_ok) begin
            next_st = ST_CTRL;
          end else begin
            next_st = ST_IGNORE;
          end
        end
        ST_CTRL: next_st = ST_HIGH;
        ST_HIGH: next_st = ST_LOW;
        ST_LOW: next_st = ST_HIGH;
        default: next_st = st;
      endcase
    end
  end

  // state register; start and stop take priority over byte traffic
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st <= ST_IDLE;
    end else if (stop_det) begin
      st <= ST_IDLE;
    end else if (start_det) begin
      st <= ST_FIRST;
    end else begin
      st <= next_st;
    end
  end

  // bit counter and shift register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bitcnt <= 4'h0;
      shift <= 7'h00;
    end else if (start_det || stop_det) begin
      bitcnt <= 4'h0;
    end else if (ack_slot) begin
      bitcnt <= 4'h0;
    end else if (bit_evt) begin
      bitcnt <= bitcnt + 4'h1;
      shift <= byte_val[6:0]; // msb first
    end
  end

  // high-speed flag: set by master code, cleared by stop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hs_mode <= 1'b0;
    end else if (stop_det) begin
      hs_mode <= 1'b0;
    end else if (byte_done && st == ST_FIRST && is_mcode) begin
      hs_mode <= 1'b1;
    end
  end

  // control byte fields and data capture
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      load_mode <= LOAD_RESET;
      broadcast_sel <= 1'b0;
      powerdown_flag <= 1'b0;
      powerdown_mode <= PDM_RESET;
      high_byte <= 8'h00;
      pend_word <= WORD_RESET;
    end else if (byte_done) begin
      if (st == ST_CTRL) begin
        load_mode <= byte_val[LOAD_MSB:LOAD_LSB];
        broadcast_sel <= byte_val[BRC_POS];
        powerdown_flag <= byte_val[PD_POS];
      end
      if (st == ST_HIGH) begin
        high_byte <= byte_val;
        if (powerdown_flag) begin
          powerdown_mode <= byte_val[PDM_MSB:PDM_LSB];
        end
      end
      if (st == ST_LOW) begin
        pend_word <= {high_byte, byte_val};
      end
    end
  end

  // acknowledge drive: pull data low from the fall after bit 8 to the fall after bit 9
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sda_oe <= 1'b0;
      ack_arm <= 1'b0;
      ack_seen <= 1'b0;
      upd_arm <= 1'b0;
    end else if (start_det || stop_det) begin
      {sda_oe, ack_arm, ack_seen, upd_arm} <= 4'h0;
    end else begin
      if (take_ack) begin
        ack_arm <= 1'b1;
        upd_arm <= (st == ST_LOW);
      end else if (scl_fall && ack_arm) begin
        ack_arm <= 1'b0;
        sda_oe <= 1'b1;
      end else if (ack_slot && sda_oe) begin
        ack_seen <= 1'b1;
      end else if (scl_fall && ack_seen) begin
        sda_oe <= 1'b0;
        ack_seen <= 1'b0;
        upd_arm <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0; // open drain: only ever pulls low

  // output update on the falling edge that closes a low byte acknowledge
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      update <= 1'b0;
      dac_word <= WORD_RESET;
    end else begin
      update <= scl_fall && ack_seen && upd_arm && !start_det && !stop_det;
      if (scl_fall && ack_seen && upd_arm && !start_det && !stop_det) begin
        dac_word <= pend_word;
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  mcode_no_ack_a: assert property (byte_done && st == ST_FIRST && is_mcode && !start_det && !stop_det |=> !ack_arm && hs_mode && st == ST_WAIT_RS)
    else $error("master code was acknowledged or did not enter high speed");
  stop_ends_hs_a: assert property (stop_det |=> !hs_mode && !sda_oe && st == ST_IDLE)
    else $error("stop did not end high speed");
  stop_keeps_out_a: assert property (stop_det |=> $stable(dac_word) && $stable(load_mode))
    else $error("stop changed output state");
  hs_entry_path_a: assert property ($rose(hs_mode) |-> $past(st) == ST_FIRST && $past(is_mcode))
    else $error("high speed entered without master code");
  addr_nack_a: assert property (byte_done && st == ST_FIRST && !is_mcode && !addr_ok && !start_det && !stop_det |=> !ack_arm && st == ST_IGNORE)
    else $error("foreign address acknowledged");
  addr_ack_a: assert property (byte_done && st == ST_FIRST && !is_mcode && addr_ok && !start_det && !stop_det |=> ack_arm && st == ST_CTRL)
    else $error("matching address not acknowledged");
  ack_release_a: assert property ($fell(sda_oe) |-> $past(scl_fall) || $past(start_det) || $past(stop_det))
    else $error("acknowledge released away from a clock fall");
  ctrl_fields_a: assert property (byte_done && st == ST_CTRL && !start_det && !stop_det |=> load_mode == $past(byte_val[5:4]) && powerdown_flag == $past(byte_val[0]))
    else $error("control byte fields not captured");
  high_then_low_a: assert property (byte_done && st == ST_HIGH && !start_det && !stop_det |=> st == ST_LOW && ack_arm)
    else $error("high byte not acknowledged");
  low_then_high_a: assert property (byte_done && st == ST_LOW && !start_det && !stop_det |=> st == ST_HIGH && ack_arm && upd_arm)
    else $error("low byte not acknowledged");
  update_timing_a: assert property (update |-> $past(scl_fall) && $past(ack_seen) && dac_word == $past(pend_word))
    else $error("update not on acknowledge falling edge");
  word_only_on_update_a: assert property ($changed(dac_word) |-> update)
    else $error("output word changed without update");
  pd_mode_a: assert property (byte_done && st == ST_HIGH && powerdown_flag && !start_det && !stop_det |=> powerdown_mode == $past(byte_val[7:5]))
    else $error("power-down mode not captured");

  // the acknowledge is only ever driven inside an addressed write frame
  oe_in_frame_a: assert property (sda_oe |-> in_frame && st != ST_FIRST)
    else $error("acknowledge driven outside an addressed frame");

  // a foreign address leaves the device silent
  ignore_quiet_a: assert property (st == ST_IGNORE |-> !ack_arm && !sda_oe)
    else $error("acknowledge while ignoring the bus");

  // after the master code nothing is acknowledged until the repeated start
  wait_rs_quiet_a: assert property (st == ST_WAIT_RS |-> !ack_arm && !sda_oe)
    else $error("acknowledge while waiting for repeated start");

  // an idle device never holds the data line
  idle_quiet_a: assert property (st == ST_IDLE |-> !sda_oe && !ack_arm)
    else $error("data line held while idle");

  // the update strobe lasts exactly one cycle
  update_pulse_a: assert property (update |=> !update)
    else $error("update longer than one cycle");

  // only a stop clears high-speed mode
  hs_only_stop_a: assert property (hs_mode && !stop_det |=> hs_mode)
    else $error("high speed left without a stop");

  // the acknowledge starts only at a clock fall after an accepted byte
  ack_rise_a: assert property ($rose(sda_oe) |-> $past(ack_arm) && $past(scl_fall))
    else $error("acknowledge started at the wrong time");

  // any start or repeated start returns to the address stage with a fresh count
  start_rearm_a: assert property (start_det |=> st == ST_FIRST && bitcnt == 4'h0 && !sda_oe)
    else $error("start did not return to addressing");

  // the power-down mode moves only while power-down is selected
  pd_mode_hold_a: assert property (!powerdown_flag |=> $stable(powerdown_mode))
    else $error("power-down mode changed without power-down");

  // the bit counter never passes the acknowledge slot
  bitcnt_range_a: assert property (bitcnt <= BIT_ACK)
    else $error("bit counter out of range");

  // the committed high byte is the one captured before the low byte
  word_pairs_a: assert property (update |-> dac_word[15:8] == $past(high_byte))
    else $error("committed high byte mismatch");

  // control fields change only on a control byte
  ctrl_hold_a: assert property (!(byte_done && st == ST_CTRL) |=> $stable(load_mode))
    else $error("load mode changed outside a control byte");

  // bytes between master code and repeated start are ignored
  wait_rs_stay_a: assert property (byte_done && st == ST_WAIT_RS && !start_det |=> st == ST_WAIT_RS)
    else $error("byte accepted before repeated start");

  // an ignored frame stays ignored until a start or stop
  ignore_stays_a: assert property (st == ST_IGNORE && !start_det && !stop_det |=> st == ST_IGNORE)
    else $error("ignored frame resumed without a start");

  // an update needs a completed low byte
  update_needs_low_a: assert property (update |-> $past(upd_arm))
    else $error("update without a low byte");

  // the low byte completes the pending word
  low_capture_a: assert property (byte_done && st == ST_LOW && !start_det && !stop_det |=> pend_word == {$past(high_byte), $past(byte_val)})
    else $error("pending word not assembled");
endmodule : hs_i2c_dac_write_slave

/* File: i2c_master_model.sv */
`timescale 1ns/1ps
// bus master partner: drives the bus clock and pulls data low, open drain
module i2c_master_model (
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic tck = 1'b0;
  // link-rate tick, 6 ns, free of the system clock phase
  initial forever #3 tck = ~tck;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one bus clock phase of 72 ns, above the 60 ns sampling minimum
  task phase();
    repeat (12) @(posedge tck);
  endtask : phase
  // start or repeated start: data falls while the clock is high
  task start();
    sda_low = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    sda_low = 1'b1;
    phase();
    scl = 1'b0;
    phase();
  endtask : start
  // stop: data rises while the clock is high
  task stop();
    sda_low = 1'b1;
    phase();
    scl = 1'b1;
    phase();
    sda_low = 1'b0;
    phase();
  endtask : stop
  // eight bits msb first, data changed only while the clock is low, then the ninth pulse
  task send(input logic [7:0] b, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      phase();
      scl = 1'b1;
      phase();
      scl = 1'b0;
    end
    sda_low = 1'b0;
    phase();
    scl = 1'b1;
    phase();
    nak = sda;
    scl = 1'b0;
  endtask : send
endmodule : i2c_master_model

/* File: test_hs_i2c_dac_write_slave.sv */
`timescale 1ns/1ps
module test_hs_i2c_dac_write_slave;
  import hs_dac_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b1;
  logic pin = 1'b0;
  logic scl, m_low, sda_out, sda_oe, hs_mode, update, broadcast_sel, powerdown_flag, nak;
  logic [15:0] dac_word;
  logic [1:0] load_mode;
  logic [2:0] powerdown_mode;
  logic [7:0] c;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32233;
  int n_upd = 0;
  // pulled-up data wire resolved from both parties
  wire sda = ~(m_low | (sda_oe & ~sda_out));
  initial forever #5 clk_sys = ~clk_sys;
  i2c_master_model i_i2c_master_model (.sda(sda), .scl(scl), .sda_low(m_low));
  hs_i2c_dac_write_slave i_hs_i2c_dac_write_slave (.clk_sys(clk_sys), .rstn(rstn), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .address_select_pin(pin),
    .hs_mode(hs_mode), .dac_word(dac_word), .update(update), .load_mode(load_mode),
    .broadcast_sel(broadcast_sel), .powerdown_flag(powerdown_flag),
    .powerdown_mode(powerdown_mode));
  // counts update pulses
  always @(posedge clk_sys) if (update === 1'b1) n_upd++;
  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  // address byte with a chosen select bit and expected answer
  task addr(input logic p, input logic exp_nak);
    i_i2c_master_model.send({ADDR_FIXED, p, ADDR_LOW_BIT, 1'b0}, nak);
    chk(nak === exp_nak, "address answer");
  endtask : addr
  task ctrl(input logic [7:0] b);
    i_i2c_master_model.send(b, nak);
    chk(nak === 1'b0, "control ack");
    chk({load_mode, broadcast_sel, powerdown_flag} === {b[5:4], b[2], b[0]}, "control");
  endtask : ctrl
  // high then low byte; one update with the full word expected
  task pair(input logic [15:0] d);
    int u;
    u = n_upd;
    i_i2c_master_model.send(d[15:8], nak);
    chk(nak === 1'b0, "high ack");
    i_i2c_master_model.send(d[7:0], nak);
    chk(nak === 1'b0, "low ack");
    repeat (12) @(posedge clk_sys);
    chk(n_upd === u + 1, "update count");
    chk(dac_word === d, "word");
    if (powerdown_flag === 1'b1) chk(powerdown_mode === d[15:13], "pd mode");
  endtask : pair
  task finish_test();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  initial begin
    #500000;
    n_errors++;
    finish_test();
  end
  initial begin
    // a true falling reset edge, so the bus-clocked sampler is cleared while the bus clock idles
    #1 rstn = 1'b0;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(hs_mode === 1'b0 && dac_word === WORD_RESET && update === 1'b0, "reset");
    for (int t = 0; t < 4; t++) begin
      @(negedge clk_sys) pin = t[0];
      c = {2'b00, 2'(t), 1'b0, 1'(t >> 1), 1'b0, 1'b0};
      i_i2c_master_model.start();
      i_i2c_master_model.send({MCODE_PREFIX, 3'($random(seed))}, nak);
      chk(nak === 1'b1, "master code nak");
      chk(hs_mode === 1'b1, "hs entered");
      i_i2c_master_model.start();
      addr(pin, 1'b0);
      ctrl(c);
      pair(16'($random(seed)));
      pair(16'hffff);
      i_i2c_master_model.start();
      addr(pin, 1'b0);
      ctrl(8'h01);
      pair({3'(t + 5), 13'h0000});
      i_i2c_master_model.send(8'($random(seed)), nak);
      i_i2c_master_model.stop();
      repeat (8) @(posedge clk_sys);
      chk(hs_mode === 1'b0, "hs left on stop");
      chk(dac_word[15:13] === 3'(t + 5) && powerdown_flag === 1'b1, "state kept");
      i_i2c_master_model.start();
      addr(~pin, 1'b1);
      i_i2c_master_model.send(8'h00, nak);
      chk(nak === 1'b1, "ignored after mismatch");
      i_i2c_master_model.stop();
      $display("test %0d done", t);
    end
    finish_test();
  end
endmodule : test_hs_i2c_dac_write_slave
